/* scsi_peer.sv */
// far-side bus devices: drive control and data lines, raise busy after a delay
`timescale 1ns/1ps
module scsi_peer (
    input  wire logic       clk_in,
    input  wire logic [7:0] ctl_in,     // asserted lines, busy down to io
    input  wire logic [7:0] data_in,
    input  wire logic [7:0] answer_in,  // cycles to answer a selection, 0 = stay off
    input  wire logic       go_in,
    output logic      [7:0] ctl_n_out,
    output logic      [7:0] data_n_out
);
    logic [7:0] cnt_r = 8'h00;
    logic       ans_r = 1'b0;

    // terminators pull released lines high, so a dropped line reads negated
    always_ff @(posedge clk_in)
    begin
        if (go_in)
            cnt_r <= answer_in;
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
        ans_r <= (answer_in != 8'h00) && (ans_r || (cnt_r == 8'h01 && !go_in));
    end

    assign ctl_n_out  = ~(ctl_in | {ans_r, 7'h00});
    assign data_n_out = ~data_in;
endmodule

/* scsi_selreg.sv */
// selection time-out, command bytes, bus snapshots, unit identify and progress registers
//
// Operation
// - selection waits busy, ends on time-out
// - zero time-out waits forever, scam select ends at once
// - normal unit is 80 over clock MHz
// - scam-tolerant unit scaled 54 over 125
// - scam select holds value units minimum
// - command bytes sent and captured
// - soft reset loads revision into first byte
// - status and complete message from bytes
// - control snapshot busy..io, writes set phase
// - handshake bits depend on target role
// - data snapshot mirrors data lines
// - initiator read bus returns req-latched byte
// - scam transfer drives and stores data
// - select-transfer identify, status, reselection unit
// - received identify copied with valid, disconnect
// - target routine accepted only single-byte
// - reselect identify uses unit and routine
// - unit register layout fixed
// - progress records stages, sets resume point
// - progress code seven bits, top zero
`timescale 1ns/1ps
module scsi_selreg
    import scsi_selreg_pkg::*;
#(
    parameter int         UNIT_NORMAL = scsi_selreg_pkg::UNIT_NORMAL_CYCLES,
    parameter int         UNIT_SEL    = scsi_selreg_pkg::UNIT_SEL_CYCLES,
    parameter logic [7:0] UCODE_REV   = 8'h5A  // arbitrary value
)(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // host register port
    input  wire logic [4:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // scsi bus pins, active low
    input  wire logic       bsy_n_in,
    input  wire logic       sel_n_in,
    input  wire logic       req_n_in,
    input  wire logic       ack_n_in,
    input  wire logic       atn_n_in,
    input  wire logic       msg_n_in,
    input  wire logic       cd_n_in,
    input  wire logic       io_n_in,
    input  wire logic [7:0] data_n_in,
    // sequencer: selection timer
    input  wire logic       sel_start_in,
    input  wire logic       scam_select_in,
    input  wire logic       scam_tolerant_in,
    input  wire logic       sel_abort_in,
    output logic            sel_response_out,
    output logic            sel_timeout_out,
    output logic            scam_hold_done_out,
    output logic            sel_busy_out,
    // sequencer: command bytes
    input  wire logic       soft_reset_in,
    input  wire logic       extended_en_in,
    input  wire logic       cdb_wr_in,
    input  wire logic [3:0] cdb_idx_in,
    input  wire logic [7:0] cdb_wdata_in,
    output logic      [7:0] cdb_rdata_out,
    output logic      [7:0] status_byte_out,
    output logic      [7:0] complete_sel_out,
    // sequencer: bus snapshots
    input  wire logic       low_level_done_in,
    input  wire logic       target_or_scam_in,
    input  wire logic       initiator_in,
    input  wire logic       read_bus_cmd_in,
    input  wire logic       req_out_state_in,
    input  wire logic       ack_out_state_in,
    input  wire logic       req_latch_in,
    input  wire logic       scam_latch_in,
    output logic      [7:0] ctl_snap_out,
    output logic      [7:0] data_drive_out,
    // sequencer: unit identify
    input  wire logic       sat_status_wr_in,
    input  wire logic [7:0] sat_status_in,
    input  wire logic       resel_unexp_in,
    input  wire logic [7:0] resel_msg_in,
    input  wire logic       wsr_ident_in,
    input  wire logic [7:0] wsr_msg_in,
    input  wire logic       single_byte_in,
    output logic      [7:0] sat_identify_out,
    output logic      [7:0] resel_identify_out,
    output logic            ident_rejected_out,
    // sequencer: progress
    input  wire logic       progress_wr_in,
    input  wire logic [6:0] progress_in,
    output logic      [6:0] resume_point_out
);
    import scsi_selreg_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [7:0] ctl_s1_r, ctl_s2_r, dat_s1_r, dat_s2_r;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ctl_s1_r <= RST_BYTE;
            ctl_s2_r <= RST_BYTE;
            dat_s1_r <= RST_BYTE;
            dat_s2_r <= RST_BYTE;
        end
        else
        begin
            // asserted = one: bsy sel req ack atn msg cd io
            ctl_s1_r <= ~{bsy_n_in, sel_n_in, req_n_in, ack_n_in, atn_n_in, msg_n_in, cd_n_in, io_n_in};
            ctl_s2_r <= ctl_s1_r;
            dat_s1_r <= ~data_n_in;
            dat_s2_r <= dat_s1_r;
        end
    end

    wire bsy_s = ctl_s2_r[7];

    // ------------------------------------------------------------------
    // selection / reselection timer
    // ------------------------------------------------------------------
    tmr_state_t            st_r, st_nxt;
    logic [PRESCALE_W-1:0] pre_r, pre_nxt, pre_lim_r, pre_lim_nxt;
    logic [7:0]            units_r, units_nxt;
    logic                  resp_r, resp_nxt, to_r, to_nxt, hold_r, hold_nxt, busy_r, busy_nxt;
    logic [7:0]            timeout_r;

    always_comb
    begin
        st_nxt      = st_r;
        pre_nxt     = pre_r;
        pre_lim_nxt = pre_lim_r;
        units_nxt   = units_r;
        resp_nxt    = 1'b0;
        to_nxt      = 1'b0;
        hold_nxt    = 1'b0;
        if (st_r != TMR_IDLE)
        begin
            if (pre_r == pre_lim_r)
            begin
                pre_nxt = '0;
                if (units_r != 8'hFF)
                    units_nxt = units_r + 8'h01;
            end
            else
                pre_nxt = pre_r + {{(PRESCALE_W-1){1'b0}}, 1'b1};
        end
        unique case (st_r)
            TMR_IDLE:
            begin
                if (sel_start_in)
                begin
                    pre_nxt   = '0;
                    units_nxt = 8'h00;
                    // unit lengths per mode
                    if (scam_select_in)
                    begin
                        st_nxt      = TMR_HOLD;
                        pre_lim_nxt = PRESCALE_W'(UNIT_SEL - 1);
                    end
                    else
                    begin
                        st_nxt      = TMR_WAIT;
                        pre_lim_nxt = scam_tolerant_in ? PRESCALE_W'(UNIT_SCAM_CYCLES - 1)
                                                       : PRESCALE_W'(UNIT_NORMAL - 1);
                    end
                end
            end
            TMR_WAIT:
            begin
                if (sel_abort_in)
                    st_nxt = TMR_IDLE;
                else if (bsy_s)
                begin
                    resp_nxt = 1'b1;
                    st_nxt   = TMR_IDLE;
                end
                else if (timeout_r != 8'h00 && units_r == timeout_r)
                begin
                    to_nxt = 1'b1;
                    st_nxt = TMR_IDLE;
                end
            end
            TMR_HOLD:
            begin
                // selection is held at least the programmed units
                if (sel_abort_in)
                    st_nxt = TMR_IDLE;
                else if (units_r >= timeout_r)
                begin
                    hold_nxt = 1'b1;
                    st_nxt   = TMR_IDLE;
                end
            end
            default:
                st_nxt = TMR_IDLE;
        endcase
        busy_nxt = (st_nxt != TMR_IDLE);
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st_r      <= TMR_IDLE;
            pre_r     <= '0;
            pre_lim_r <= '0;
            units_r   <= 8'h00;
            resp_r    <= 1'b0;
            to_r      <= 1'b0;
            hold_r    <= 1'b0;
            busy_r    <= 1'b0;
        end
        else
        begin
            st_r      <= st_nxt;
            pre_r     <= pre_nxt;
            pre_lim_r <= pre_lim_nxt;
            units_r   <= units_nxt;
            resp_r    <= resp_nxt;
            to_r      <= to_nxt;
            hold_r    <= hold_nxt;
            busy_r    <= busy_nxt;
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [7:0] timeout_nxt, ctl_r, ctl_nxt, dsnap_r, dsnap_nxt, lun_r, lun_nxt;
    logic [7:0] req_byte_r, req_byte_nxt, rdata_r, rdata_nxt;
    logic [6:0] phase_r, phase_nxt;
    logic [7:0] cdb_r [CDB_COUNT];
    logic [7:0] cdb_nxt [CDB_COUNT];
    logic [7:0] cdb_rd_r, cdb_rd_nxt;
    logic       rej_r, rej_nxt;

    function automatic logic hit_cdb(input logic [4:0] a, input int i);
        hit_cdb = (a == 5'(ADDR_CDB_FIRST + i));
    endfunction

    always_comb
    begin
        logic id_ok;
        id_ok        = 1'b0;
        timeout_nxt  = timeout_r;
        ctl_nxt      = ctl_r;
        dsnap_nxt    = dsnap_r;
        lun_nxt      = lun_r;
        phase_nxt    = phase_r;
        req_byte_nxt = req_byte_r;
        rej_nxt      = 1'b0;
        rdata_nxt    = rdata_r;
        cdb_nxt      = cdb_r;
        // host writes first; same-cycle sequencer updates below take precedence
        if (reg_wr_in)
        begin
            if (reg_addr_in == ADDR_TIMEOUT)   timeout_nxt = reg_wdata_in;
            if (reg_addr_in == ADDR_CTL_SNAP)  ctl_nxt     = reg_wdata_in;
            if (reg_addr_in == ADDR_DATA_SNAP) dsnap_nxt   = reg_wdata_in;
            if (reg_addr_in == ADDR_LUN)       lun_nxt     = reg_wdata_in & 8'hE7;
            if (reg_addr_in == ADDR_PHASE)     phase_nxt   = reg_wdata_in[PHASE_MSB:0];
            for (int i = 0; i < CDB_COUNT; i++)
                if (hit_cdb(reg_addr_in, i))
                    cdb_nxt[i] = reg_wdata_in;
        end
        // received command bytes captured
        if (cdb_wr_in && cdb_idx_in < 4'(CDB_COUNT))
            cdb_nxt[cdb_idx_in] = cdb_wdata_in;
        if (soft_reset_in && extended_en_in)
            cdb_nxt[IDX_FIRST] = UCODE_REV;
        cdb_rd_nxt = (cdb_idx_in < 4'(CDB_COUNT)) ? cdb_r[cdb_idx_in] : RST_BYTE;
        // latch inbound byte on each req pulse; outbound leaves it stale
        if (req_latch_in && ctl_s2_r[0])
            req_byte_nxt = dat_s2_r;
        if (low_level_done_in)
        begin
            // handshake bits swap meaning by role
            ctl_nxt = {ctl_s2_r[7:6],
                       target_or_scam_in ? ctl_s2_r[5] : ctl_s2_r[4],
                       target_or_scam_in ? ack_out_state_in : req_out_state_in,
                       ctl_s2_r[3:0]};
            dsnap_nxt = (read_bus_cmd_in && initiator_in) ? req_byte_r : dat_s2_r;
        end
        if (scam_latch_in)
            dsnap_nxt = dat_s2_r;
        // unit register updates
        if (sat_status_wr_in)
            lun_nxt = sat_status_in;
        if (resel_unexp_in && extended_en_in)
            lun_nxt = {2'b00, resel_msg_in[LUN_TRN_BIT], 2'b00, resel_msg_in[2:0]};
        if (wsr_ident_in)
        begin
            id_ok = wsr_msg_in[MSG_IDENT_BIT] && (!wsr_msg_in[LUN_TRN_BIT] || single_byte_in);
            rej_nxt = !id_ok;
            // copy of identify with valid and disconnect flags
            lun_nxt = {id_ok, id_ok & wsr_msg_in[LUN_DOK_BIT], wsr_msg_in[LUN_TRN_BIT] & id_ok,
                       2'b00, wsr_msg_in[2:0] & {3{id_ok}}};
        end
        if (progress_wr_in)
            phase_nxt = progress_in;
        // read mux, registered
        if (reg_rd_in)
        begin
            rdata_nxt = RST_BYTE;
            unique case (reg_addr_in)
                ADDR_TIMEOUT:   rdata_nxt = timeout_r;
                ADDR_CTL_SNAP:  rdata_nxt = ctl_r;
                ADDR_DATA_SNAP: rdata_nxt = dsnap_r;
                ADDR_LUN:       rdata_nxt = lun_r;
                ADDR_PHASE:     rdata_nxt = {1'b0, phase_r};
                default:
                    for (int i = 0; i < CDB_COUNT; i++)
                        if (hit_cdb(reg_addr_in, i))
                            rdata_nxt = cdb_r[i];
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            timeout_r  <= RST_BYTE;
            ctl_r      <= RST_BYTE;
            dsnap_r    <= RST_BYTE;
            lun_r      <= RST_BYTE;
            phase_r    <= '0;
            req_byte_r <= RST_BYTE;
            rej_r      <= 1'b0;
            rdata_r    <= RST_BYTE;
            cdb_rd_r   <= RST_BYTE;
            for (int i = 0; i < CDB_COUNT; i++)
                cdb_r[i] <= RST_BYTE;
        end
        else
        begin
            timeout_r  <= timeout_nxt;
            ctl_r      <= ctl_nxt;
            dsnap_r    <= dsnap_nxt;
            lun_r      <= lun_nxt;
            phase_r    <= phase_nxt;
            req_byte_r <= req_byte_nxt;
            rej_r      <= rej_nxt;
            rdata_r    <= rdata_nxt;
            cdb_rd_r   <= cdb_rd_nxt;
            cdb_r      <= cdb_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------------
    assign reg_rdata_out      = rdata_r;
    assign sel_response_out   = resp_r;
    assign sel_timeout_out    = to_r;
    assign scam_hold_done_out = hold_r;
    assign sel_busy_out       = busy_r;
    assign cdb_rdata_out      = cdb_rd_r;
    assign status_byte_out    = cdb_r[IDX_STATUS];
    assign complete_sel_out   = cdb_r[IDX_COMPLETE];
    assign ctl_snap_out       = ctl_r;
    assign data_drive_out     = dsnap_r;
    // host is expected to leave valid clear before select-and-transfer
    assign sat_identify_out   = {1'b1, lun_r[LUN_DOK_BIT], lun_r[LUN_TRN_BIT], 2'b00, lun_r[2:0]};
    assign resel_identify_out = {1'b1, 1'b0, lun_r[LUN_TRN_BIT], 2'b00, lun_r[2:0] & LUN_MASK};
    assign ident_rejected_out = rej_r;
    assign resume_point_out   = phase_r;

endmodule

/* scsi_selreg_chk.sv */
// assertions on the selection-phase register bank ports
`timescale 1ns/1ps
module scsi_selreg_chk
    import scsi_selreg_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       sel_start_in,
    input wire logic       sel_busy_out,
    input wire logic       sel_response_out,
    input wire logic       sel_timeout_out,
    input wire logic       scam_hold_done_out,
    input wire logic       cdb_wr_in,
    input wire logic [3:0] cdb_idx_in,
    input wire logic [7:0] cdb_wdata_in,
    input wire logic [7:0] status_byte_out,
    input wire logic [7:0] complete_sel_out,
    input wire logic       wsr_ident_in,
    input wire logic       ident_rejected_out,
    input wire logic       progress_wr_in,
    input wire logic [6:0] progress_in,
    input wire logic [6:0] resume_point_out
);
    default clocking dcb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic res;
    assign res = sel_response_out | sel_timeout_out | scam_hold_done_out;

    property follow_p(logic go, logic [7:0] src, logic [7:0] dst);
        logic [7:0] v;
        (go, v = src) |=> (dst == v);
    endproperty

    chk_lun_zero_bits: assert property (
        reg_rd_in && reg_addr_in == ADDR_LUN |=> reg_rdata_out[4:3] == 2'h0) else $error("unit bits 4:3 set");
    chk_phase_top_zero: assert property (
        reg_rd_in && reg_addr_in == ADDR_PHASE |=> !reg_rdata_out[7]) else $error("progress bit 7 set");
    chk_status_follow: assert property (
        follow_p(cdb_wr_in && cdb_idx_in == IDX_STATUS, cdb_wdata_in, status_byte_out)) else $error("status stale");
    chk_complete_follow: assert property (
        follow_p(cdb_wr_in && cdb_idx_in == IDX_COMPLETE, cdb_wdata_in, complete_sel_out))
        else $error("complete stale");
    chk_resume_follow: assert property (
        follow_p(progress_wr_in, {1'b0, progress_in}, {1'b0, resume_point_out})) else $error("resume point stale");
    chk_busy_cause: assert property ($rose(sel_busy_out) |-> $past(sel_start_in))
        else $error("timer busy without start");
    chk_result_ends: assert property (res |-> $past(sel_busy_out) && !sel_busy_out)
        else $error("timer result outside a wait");
    chk_result_single: assert property (res |=> !res)
        else $error("timer result longer than one cycle");
    chk_reject_cause: assert property (ident_rejected_out |-> $past(wsr_ident_in))
        else $error("identify rejected without a message");

    cover property (sel_response_out);
    cover property (sel_timeout_out);
    cover property (scam_hold_done_out);
    cover property (ident_rejected_out);
endmodule

/* scsi_selreg_pkg.sv */
// constants shared by the selection-phase register bank
package scsi_selreg_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ            = 20;
    localparam int CYC_PER_MS_PER_MHZ = 1000;
    localparam int TO_DIV_NORMAL      = 80;
    localparam int TO_NUM_SCAM        = 125;
    localparam int TO_DEN_SCAM        = 54;
    localparam int TO_DIV_SCAM_SEL    = 20;
    // one register unit = divisor / clk_mhz milliseconds
    localparam int UNIT_NORMAL_CYCLES = (TO_DIV_NORMAL * CYC_PER_MS_PER_MHZ * CLK_MHZ) / CLK_MHZ;
    localparam int UNIT_SCAM_CYCLES   = (TO_DEN_SCAM * CYC_PER_MS_PER_MHZ * CLK_MHZ) / (TO_NUM_SCAM * CLK_MHZ);
    localparam int UNIT_SEL_CYCLES    = (TO_DIV_SCAM_SEL * CYC_PER_MS_PER_MHZ * CLK_MHZ) / CLK_MHZ;
    localparam int PRESCALE_W         = 17;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_TIMEOUT   = 5'h02;
    localparam logic [4:0] ADDR_CDB_FIRST = 5'h03;
    localparam logic [4:0] ADDR_LUN       = 5'h0F;
    localparam logic [4:0] ADDR_PHASE     = 5'h10;
    localparam logic [4:0] ADDR_CTL_SNAP  = 5'h17;
    localparam logic [4:0] ADDR_DATA_SNAP = 5'h19;
    localparam int         CDB_COUNT      = 12;
    localparam int         IDX_FIRST      = 0;
    localparam int         IDX_STATUS     = 10;
    localparam int         IDX_COMPLETE   = 11;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int LUN_VALID_BIT = 7;
    localparam int LUN_DOK_BIT   = 6;
    localparam int LUN_TRN_BIT   = 5;
    localparam int MSG_IDENT_BIT = 7;
    localparam int PHASE_MSB     = 6;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] LUN_MASK = 3'h7;

    // ------------------------------------------------------------------
    // timer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TMR_IDLE = 3'b001,
        TMR_WAIT = 3'b010,
        TMR_HOLD = 3'b100
    } tmr_state_t;

endpackage

/* scsi_selreg_tb.sv */
// self-checking bench for the selection-phase register bank
`timescale 1ns/1ps
module scsi_selreg_tb;
    import scsi_selreg_pkg::*;

    localparam logic [7:0] REV = 8'h3D;  // arbitrary revision value
    logic       clk_in, rst_n_in, reg_wr_in, reg_rd_in, sel_start_in, scam_select_in, scam_tolerant_in;
    logic       bsy_n_in, sel_n_in, req_n_in, ack_n_in, atn_n_in, msg_n_in, cd_n_in, io_n_in, sel_abort_in;
    logic       sel_response_out, sel_timeout_out, scam_hold_done_out, sel_busy_out, soft_reset_in;
    logic       extended_en_in, cdb_wr_in, low_level_done_in, target_or_scam_in, initiator_in;
    logic       read_bus_cmd_in, req_out_state_in, ack_out_state_in, req_latch_in, scam_latch_in;
    logic       sat_status_wr_in, resel_unexp_in, wsr_ident_in, single_byte_in, ident_rejected_out, progress_wr_in;
    logic [3:0] cdb_idx_in;
    logic [4:0] reg_addr_in;
    logic [6:0] progress_in, resume_point_out;
    logic [7:0] reg_wdata_in, reg_rdata_out, data_n_in, ctl_n, ctl, dat, answer, cdb_wdata_in;
    logic [7:0] cdb_rdata_out, status_byte_out, complete_sel_out, ctl_snap_out, data_drive_out;
    logic [7:0] sat_status_in, resel_msg_in, wsr_msg_in, sat_identify_out, resel_identify_out;
    logic [10:0] p;
    logic [4:0] addrs [7] = '{ADDR_TIMEOUT, ADDR_CDB_FIRST, ADDR_LUN, ADDR_PHASE, ADDR_CTL_SNAP, ADDR_DATA_SNAP, 5'h1F};
    logic [7:0] msgs [4] = '{8'hC5, 8'hA1, 8'hA1, 8'h45};
    logic [7:0] exps [4] = '{8'hC5, 8'h00, 8'hA1, 8'h00};
    int         num_errors, tests_run, cyc;

    assign {progress_wr_in, wsr_ident_in, resel_unexp_in, sat_status_wr_in, scam_latch_in, req_latch_in,
            low_level_done_in, cdb_wr_in, soft_reset_in, sel_abort_in, sel_start_in} = p;
    assign {bsy_n_in, sel_n_in, req_n_in, ack_n_in, atn_n_in, msg_n_in, cd_n_in, io_n_in} = ctl_n;

    scsi_selreg #(.UNIT_NORMAL(8), .UNIT_SEL(4), .UCODE_REV(REV)) scsi_selreg_inst (.*);
    scsi_peer scsi_peer_inst (.clk_in(clk_in), .ctl_in(ctl), .data_in(dat), .answer_in(answer),
                              .go_in(sel_start_in), .ctl_n_out(ctl_n), .data_n_out(data_n_in));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string what);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        chk(what, reg_rdata_out, e);
    endtask

    task automatic fire(input int b);
        @(posedge clk_in);
        p[b] <= 1'b1;
        @(posedge clk_in);
        p[b] <= 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic timer(input logic [7:0] v, input logic [1:0] m, input logic [7:0] a, input int lo, input int hi,
                         input logic [2:0] kind);
        int n;
        @(posedge clk_in);
        answer <= 8'h00;
        wr(ADDR_TIMEOUT, v);
        {scam_tolerant_in, scam_select_in} <= m;
        @(posedge clk_in);
        p[0] <= 1'b1;
        answer <= a;
        @(posedge clk_in);
        p[0] <= 1'b0;
        n = 0;
        while (n < hi + 2 && {sel_response_out, sel_timeout_out, scam_hold_done_out} === 3'b000)
        begin
            @(negedge clk_in);
            n++;
        end
        chk("timer result", {5'h00, sel_response_out, sel_timeout_out, scam_hold_done_out}, {5'h00, kind});
        chk("timer delay", {7'h00, n >= lo && n <= hi}, 8'h01);
    endtask

    task automatic results();
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, ctl, dat, answer, p, progress_in} = '0;
        {scam_select_in, scam_tolerant_in, extended_en_in, cdb_idx_in, cdb_wdata_in, target_or_scam_in} = '0;
        {initiator_in, read_bus_cmd_in, req_out_state_in, sat_status_in, resel_msg_in, wsr_msg_in} = '0;
        {single_byte_in, num_errors, tests_run, cyc} = '0;
        ack_out_state_in = 1'b1;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (addrs[i]) rd(addrs[i], 8'h00, "reset value");
        wr(ADDR_LUN, 8'hFF);
        rd(ADDR_LUN, 8'hE7, "unit layout");
        wr(ADDR_PHASE, 8'hFF);
        rd(ADDR_PHASE, 8'h7F, "progress layout");
        wr(ADDR_LUN, 8'h25);
        repeat (2) @(negedge clk_in);
        wr(ADDR_LUN, 8'hE5);
        repeat (2) @(negedge clk_in);
        chk("reselect identify", resel_identify_out, 8'hA5);
        chk("reselect unit", {2'h0, resel_identify_out[5:0]}, 8'h25);
        chk("select identify", sat_identify_out, 8'hE5);
        for (int i = 0; i < CDB_COUNT; i++)
            wr(ADDR_CDB_FIRST + 5'(i), 8'h10 + 8'(i));
        @(posedge clk_in);
        cdb_idx_in <= 4'h7;
        repeat (2) @(negedge clk_in);
        chk("command byte out", cdb_rdata_out, 8'h17);
        for (int k = 10; k < 12; k++)
        begin
            @(posedge clk_in);
            cdb_idx_in <= 4'(k);
            cdb_wdata_in <= 8'hC0 + 8'(k);
            fire(3);
            rd(ADDR_CDB_FIRST + 5'(k), 8'hC0 + 8'(k), "captured byte");
        end
        chk("status byte", status_byte_out, 8'hCA);
        chk("complete select", complete_sel_out, 8'hCB);
        @(posedge clk_in);
        extended_en_in <= 1'b1;
        fire(2);
        rd(ADDR_CDB_FIRST, REV, "revision byte");
        @(posedge clk_in);
        ctl <= 8'h6B;
        dat <= 8'h3C;
        for (int t = 0; t < 2; t++)
        begin
            @(posedge clk_in);
            target_or_scam_in <= t[0];
            fire(4);
            rd(ADDR_CTL_SNAP, t ? 8'h7B : 8'h4B, "control snapshot");
        end
        @(posedge clk_in);
        initiator_in <= 1'b1;
        read_bus_cmd_in <= 1'b1;
        fire(5);
        @(posedge clk_in);
        dat <= 8'h81;
        repeat (2) @(posedge clk_in);
        fire(4);
        rd(ADDR_DATA_SNAP, 8'h3C, "latched data");
        @(posedge clk_in);
        initiator_in <= 1'b0;
        read_bus_cmd_in <= 1'b0;
        fire(4);
        rd(ADDR_DATA_SNAP, 8'h81, "data snapshot");
        wr(ADDR_DATA_SNAP, 8'hA5);
        wr(ADDR_CTL_SNAP, 8'h07);
        repeat (2) @(negedge clk_in);
        chk("drive byte", data_drive_out, 8'hA5);
        chk("set phase", ctl_snap_out, 8'h07);
        @(posedge clk_in);
        dat <= 8'h5A;
        repeat (2) @(posedge clk_in);
        fire(6);
        rd(ADDR_DATA_SNAP, 8'h5A, "scam latch");
        wr(ADDR_LUN, 8'h03);
        @(posedge clk_in);
        sat_status_in <= 8'h02;
        resel_msg_in <= 8'hA3;
        fire(7);
        rd(ADDR_LUN, 8'h02, "status in unit");
        fire(8);
        rd(ADDR_LUN, 8'h23, "reselecting unit");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_in);
            wsr_msg_in <= msgs[k];
            single_byte_in <= (k == 2);
            fire(9);
            rd(ADDR_LUN, exps[k], "received identify");
        end
        @(posedge clk_in);
        progress_in <= 7'h55;
        fire(10);
        chk("resume point", {1'b0, resume_point_out}, 8'h55);
        rd(ADDR_PHASE, 8'h55, "progress");
        timer(8'h02, 2'b00, 8'h00, 16, 19, 3'b010);
        timer(8'h05, 2'b00, 8'h0A, 12, 16, 3'b100);
        timer(8'h00, 2'b00, 8'hC8, 202, 206, 3'b100);
        timer(8'h01, 2'b10, 8'h00, 432, 435, 3'b010);
        timer(8'h03, 2'b01, 8'h00, 12, 14, 3'b001);
        fire(0);
        fire(1);
        chk("timer abort", {7'h00, sel_busy_out}, 8'h00);
        results();
    end
endmodule

bind scsi_selreg scsi_selreg_chk scsi_selreg_chk_inst (.*);
